// ===== pkg/flash_status_params.svh
/*
 * Bit positions, reset values and timing counts of the flash status
 * register bank. Assumes inclusion by bare name from the design files.
 */
`ifndef FLASH_STATUS_PARAMS_SVH
`define FLASH_STATUS_PARAMS_SVH

`define ST1_BUSY_BIT 0
`define ST1_WPL_BIT 1
`define ST1_RANGE_LSB 2
`define ST1_BOTTOM_BIT 5
`define ST1_SMALL_BIT 6
`define ST1_LOCK_LO_BIT 7
`define ST2_LOCK_HI_BIT 0
`define ST2_QUAD_BIT 1
`define ST2_PROG_PAUSE_BIT 2
`define ST2_INVERT_BIT 6
`define ST2_ERASE_PAUSE_BIT 7
`define ST3_DUMMY_BIT 0
`define ST3_SCHEME_BIT 2
`define ST3_STANDBY_BIT 4
`define ST3_DRIVE_LSB 5
`define ST3_PINFN_BIT 7

`define ST1_RESET 8'h00
`define ST2_RESET 8'h00
`define ST3_RESET 8'h10
`define ST1_WRITE_MASK 8'hFC
`define ST2_WRITE_MASK 8'h7B
`define ST3_WRITE_MASK 8'hF5

`define DUMMY_BB_SHORT 4'h4
`define DUMMY_BB_LONG 4'h8
`define DUMMY_EB_SHORT 4'h6
`define DUMMY_EB_LONG 4'hA

`define WRITE_TIME_CYCLES 16'h0010
`define PROGRAM_TIME_CYCLES 16'h0040
`define ERASE_TIME_CYCLES 16'h0100

`endif

// ===== pkg/flash_status_pkg.sv
/*
 * Types of the flash status register bank: opcodes and sequencer states.
 * Assumes nothing of its surroundings.
 */
package flash_status_pkg;

    typedef enum logic [7:0] {
        OP_WRITE_ENABLE = 8'h06,
        OP_WRITE_DISABLE = 8'h04,
        OP_READ_ST1 = 8'h05,
        OP_READ_ST2 = 8'h35,
        OP_READ_ST3 = 8'h15,
        OP_WRITE_ST1 = 8'h01,
        OP_WRITE_ST2 = 8'h31,
        OP_WRITE_ST3 = 8'h11,
        OP_PAGE_PROGRAM = 8'h02,
        OP_SECTOR_ERASE = 8'h20,
        OP_BLOCK_ERASE = 8'hD8,
        OP_CHIP_ERASE = 8'hC7,
        OP_SUSPEND = 8'h75,
        OP_RESUME = 8'h7A,
        OP_SOFT_RESET = 8'h99,
        OP_QUAD_FAST_READ = 8'hEB,
        OP_DUAL_FAST_READ = 8'hBB
    } opcode_type;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_BUSY = 4'b0010,
        ST_PAUSED = 4'b0100,
        ST_DONE = 4'b1000
    } op_state_type;

    typedef enum logic [1:0] {
        KIND_WRITE = 2'h0,
        KIND_PROGRAM = 2'h1,
        KIND_ERASE = 2'h2
    } op_kind_type;

endpackage : flash_status_pkg

// ===== pkg/op_timer_if.sv
/*
 * Carrier between the status bank and its embedded-operation timer.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
interface op_timer_if;
    logic start;
    logic [15:0] length;
    logic hold;
    logic done;
    modport owner (output start, output length, output hold, input done);
    modport timer (input start, input length, input hold, output done);
endinterface : op_timer_if

// ===== hdl/op_timer.sv
/*
 * Countdown timer for an embedded operation; pauses while held.
 * Assumes a start pulse and a stable length from the owner.
 */
`timescale 1ns/1ps
module op_timer (
    input wire logic clk,
    input wire logic nrst,
    op_timer_if.timer tif
);
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic done_q;
    logic done_d;

    always_comb begin
        count_d = count_q;
        done_d = 1'b0;
        if (tif.start) begin
            count_d = tif.length;
        end else if (count_q != 16'h0000 && !tif.hold) begin
            count_d = count_q - 16'h0001;
            done_d = (count_q == 16'h0001);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count_q <= 16'h0000;
            done_q <= 1'b0;
        end else begin
            count_q <= count_d;
            done_q <= done_d;
        end
    end

    assign tif.done = done_q;
endmodule : op_timer

// ===== hdl/flash_status_regs.sv
/*
 * Status and configuration registers of a serial NOR flash: busy and write
 * permit, array protect fields, lock modes, suspend flags and pin roles.
 * Assumes decoded commands arrive as one-cycle strobes synchronous to clk,
 * with the data byte of a status write on cmd_data.
 */
`timescale 1ns/1ps
`include "flash_status_params.svh"

// Operation
// - Status three bit 7 picks pause pin (0) or restart pin (1).
// - Pin role only honoured while quad enable is clear.
// - Status three bits 6:5 set read drive strength, default zero.
// - Status three bit 2 picks range protection or per-block locks.
// - Status three bit 0 selects dummy cycle count before read data.
// - Status one bit 0 busy during program, erase or status write.
// - While busy, only read status and, during program or erase, suspend are accepted.
// - Write enable sets the write permit latch, status one bit 1.
// - Permit cleared at reset and after disable, program, erase, write.
// - Status one bits 4:2 protect range, set by status write, default 0.
// - Status one bit 5 grows range from top (0) or bottom (1).
// - Status one bit 6 counts range in 4 KB sectors or 64 KB blocks.
// - Status two bit 6 inverts protected and unprotected areas.
// - Lock bits at status two bit 0 (high) and status one bit 7 (low).
// - Lock 00: guard pin ignored, writes allowed once permit set.
// - Lock 01: writes blocked while guard pin low, allowed when high.
// - Lock 10: no writes until power cycle or soft reset clears lock.
// - Lock 11: status writes refused until power cycle; soft reset keeps lock.
// - Suspend sets erase or program paused flag by operation kind.
// - Resume or power cycle clears both paused flags.
// - Dummy select: BBh 4 or 8, EBh 6 or 10 cycles.
// - Quad enable turns the pause/restart pin into data; guard pin still honoured.
// - Program, erase, status write accepted only with permit set.
module flash_status_regs #(
    parameter logic [15:0] WRITE_CYCLES = `WRITE_TIME_CYCLES,
    parameter logic [15:0] PROGRAM_CYCLES = `PROGRAM_TIME_CYCLES,
    parameter logic [15:0] ERASE_CYCLES = `ERASE_TIME_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_opcode,
    input wire logic [7:0] cmd_data,
    input wire logic write_guard_n,
    input wire logic shared_pin_n,
    output logic [7:0] status_one,
    output logic [7:0] status_two,
    output logic [7:0] status_three,
    output logic [7:0] read_data,
    output logic cmd_refused,
    output logic [3:0] dummy_bb,
    output logic [3:0] dummy_eb,
    output logic [1:0] drive_strength,
    output logic pause_active,
    output logic restart_active,
    output logic quad_pins_data,
    output logic scheme_block_locks,
    output logic low_standby
);
    op_timer_if tif ();
    op_timer u_timer (.clk(clk), .nrst(nrst), .tif(tif));

    flash_status_pkg::op_state_type state_q, state_d;
    flash_status_pkg::op_kind_type kind_q, kind_d;
    logic [7:0] st1_q, st1_d, st2_q, st2_d, st3_q, st3_d;
    logic [7:0] pend_data_q, pend_data_d;
    logic [1:0] pend_reg_q, pend_reg_d;
    logic [7:0] rd_q, rd_d;
    logic refused_q, refused_d;
    logic start_d;
    logic [15:0] length_d;
    logic [3:0] dbb_q, dbb_d, deb_q, deb_d;
    logic [1:0] drv_q, drv_d;
    logic pause_q, pause_d, restart_q, restart_d, quad_q, quad_d;
    logic scheme_q, scheme_d, standby_q, standby_d;

    function automatic logic is_status_read(input logic [7:0] op);
        is_status_read = op == flash_status_pkg::OP_READ_ST1
            || op == flash_status_pkg::OP_READ_ST2
            || op == flash_status_pkg::OP_READ_ST3;
    endfunction : is_status_read

    // Lock mode check on status writes
    function automatic logic lock_permits(input logic hi, input logic lo,
                                          input logic guard_n);
        case ({hi, lo})
            2'b00: lock_permits = 1'b1;
            2'b01: lock_permits = guard_n;
            2'b10: lock_permits = 1'b0;
            default: lock_permits = 1'b0;
        endcase
    endfunction : lock_permits

    logic busy, permit, lock_hi, lock_lo, write_ok;
    always_comb begin
        busy = st1_q[`ST1_BUSY_BIT];
        permit = st1_q[`ST1_WPL_BIT];
        lock_hi = st2_q[`ST2_LOCK_HI_BIT];
        lock_lo = st1_q[`ST1_LOCK_LO_BIT];
        write_ok = permit && lock_permits(lock_hi, lock_lo, write_guard_n);
    end

    // Command sequencer and register next state
    always_comb begin
        state_d = state_q;
        kind_d = kind_q;
        st1_d = st1_q;
        st2_d = st2_q;
        st3_d = st3_q;
        pend_data_d = pend_data_q;
        pend_reg_d = pend_reg_q;
        rd_d = rd_q;
        refused_d = 1'b0;
        start_d = 1'b0;
        length_d = WRITE_CYCLES;
        if (cmd_valid && busy && !is_status_read(cmd_opcode)) begin
            refused_d = 1'b1;
        end else if (cmd_valid) begin
            case (cmd_opcode)
                flash_status_pkg::OP_READ_ST1: rd_d = st1_q;
                flash_status_pkg::OP_READ_ST2: rd_d = st2_q;
                flash_status_pkg::OP_READ_ST3: rd_d = st3_q;
                flash_status_pkg::OP_WRITE_ENABLE:
                    st1_d[`ST1_WPL_BIT] = 1'b1;
                flash_status_pkg::OP_WRITE_DISABLE:
                    st1_d[`ST1_WPL_BIT] = 1'b0;
                flash_status_pkg::OP_WRITE_ST1,
                flash_status_pkg::OP_WRITE_ST2,
                flash_status_pkg::OP_WRITE_ST3: begin
                    if (write_ok) begin
                        pend_data_d = cmd_data;
                        pend_reg_d = cmd_opcode[5:4];
                        kind_d = flash_status_pkg::KIND_WRITE;
                        st1_d[`ST1_BUSY_BIT] = 1'b1;
                        start_d = 1'b1;
                        state_d = flash_status_pkg::ST_BUSY;
                    end else begin
                        refused_d = 1'b1;
                    end
                    st1_d[`ST1_WPL_BIT] = 1'b0;
                end
                flash_status_pkg::OP_PAGE_PROGRAM,
                flash_status_pkg::OP_SECTOR_ERASE,
                flash_status_pkg::OP_BLOCK_ERASE,
                flash_status_pkg::OP_CHIP_ERASE: begin
                    if (permit) begin
                        kind_d = (cmd_opcode ==
                            flash_status_pkg::OP_PAGE_PROGRAM)
                            ? flash_status_pkg::KIND_PROGRAM
                            : flash_status_pkg::KIND_ERASE;
                        length_d = (cmd_opcode ==
                            flash_status_pkg::OP_PAGE_PROGRAM)
                            ? PROGRAM_CYCLES : ERASE_CYCLES;
                        st1_d[`ST1_BUSY_BIT] = 1'b1;
                        start_d = 1'b1;
                        state_d = flash_status_pkg::ST_BUSY;
                    end else begin
                        refused_d = 1'b1;
                    end
                    st1_d[`ST1_WPL_BIT] = 1'b0;
                end
                flash_status_pkg::OP_RESUME: begin
                    st2_d[`ST2_ERASE_PAUSE_BIT] = 1'b0;
                    st2_d[`ST2_PROG_PAUSE_BIT] = 1'b0;
                    if (state_q == flash_status_pkg::ST_PAUSED) begin
                        st1_d[`ST1_BUSY_BIT] = 1'b1;
                        state_d = flash_status_pkg::ST_BUSY;
                    end
                end
                flash_status_pkg::OP_SOFT_RESET: begin
                    if (lock_hi && !lock_lo) begin
                        st2_d[`ST2_LOCK_HI_BIT] = 1'b0;
                        st1_d[`ST1_LOCK_LO_BIT] = 1'b0;
                    end
                    st1_d[`ST1_WPL_BIT] = 1'b0;
                    st2_d[`ST2_ERASE_PAUSE_BIT] = 1'b0;
                    st2_d[`ST2_PROG_PAUSE_BIT] = 1'b0;
                    if (state_q == flash_status_pkg::ST_PAUSED) begin
                        state_d = flash_status_pkg::ST_IDLE;
                    end
                end
                default: ;
            endcase
        end
        // Suspend is the one non-read command accepted while busy on program/erase
        if (cmd_valid && cmd_opcode == flash_status_pkg::OP_SUSPEND
            && state_q == flash_status_pkg::ST_BUSY
            && kind_q != flash_status_pkg::KIND_WRITE && !tif.done) begin
            refused_d = 1'b0;
            st1_d[`ST1_BUSY_BIT] = 1'b0;
            if (kind_q == flash_status_pkg::KIND_ERASE) begin
                st2_d[`ST2_ERASE_PAUSE_BIT] = 1'b1;
            end else begin
                st2_d[`ST2_PROG_PAUSE_BIT] = 1'b1;
            end
            state_d = flash_status_pkg::ST_PAUSED;
        end
        case (state_q)
            flash_status_pkg::ST_IDLE: ;
            flash_status_pkg::ST_BUSY: begin
                if (tif.done) begin
                    state_d = flash_status_pkg::ST_DONE;
                end
            end
            flash_status_pkg::ST_PAUSED: ;
            flash_status_pkg::ST_DONE: begin
                if (kind_q == flash_status_pkg::KIND_WRITE) begin
                    case (pend_reg_q)
                        2'b00: st1_d = (st1_q & ~`ST1_WRITE_MASK)
                            | (pend_data_q & `ST1_WRITE_MASK);
                        2'b11: st2_d = (st2_q & ~`ST2_WRITE_MASK)
                            | (pend_data_q & `ST2_WRITE_MASK);
                        default: st3_d = pend_data_q
                            & `ST3_WRITE_MASK;
                    endcase
                end
                st1_d[`ST1_BUSY_BIT] = 1'b0;
                st1_d[`ST1_WPL_BIT] = 1'b0;
                state_d = flash_status_pkg::ST_IDLE;
            end
            default: state_d = flash_status_pkg::ST_IDLE;
        endcase
    end

    assign tif.start = start_d;
    assign tif.length = length_d;
    assign tif.hold = (state_q == flash_status_pkg::ST_PAUSED);

    // Configuration decode onto pins and read path
    always_comb begin
        quad_d = st2_q[`ST2_QUAD_BIT];
        pause_d = !quad_d && !st3_q[`ST3_PINFN_BIT]
            && !shared_pin_n;
        restart_d = !quad_d && st3_q[`ST3_PINFN_BIT]
            && !shared_pin_n;
        drv_d = st3_q[`ST3_DRIVE_LSB +: 2];
        standby_d = !st3_q[`ST3_STANDBY_BIT];
        scheme_d = st3_q[`ST3_SCHEME_BIT];
        dbb_d = st3_q[`ST3_DUMMY_BIT] ? `DUMMY_BB_LONG
            : `DUMMY_BB_SHORT;
        deb_d = st3_q[`ST3_DUMMY_BIT] ? `DUMMY_EB_LONG
            : `DUMMY_EB_SHORT;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= flash_status_pkg::ST_IDLE;
            kind_q <= flash_status_pkg::KIND_WRITE;
            st1_q <= `ST1_RESET;
            st2_q <= `ST2_RESET;
            st3_q <= `ST3_RESET;
            pend_data_q <= 8'h00;
            pend_reg_q <= 2'b00;
            rd_q <= 8'h00;
            refused_q <= 1'b0;
            dbb_q <= `DUMMY_BB_SHORT;
            deb_q <= `DUMMY_EB_SHORT;
            drv_q <= 2'b00;
            pause_q <= 1'b0;
            restart_q <= 1'b0;
            quad_q <= 1'b0;
            scheme_q <= 1'b0;
            standby_q <= 1'b0;
        end else begin
            state_q <= state_d;
            kind_q <= kind_d;
            st1_q <= st1_d;
            st2_q <= st2_d;
            st3_q <= st3_d;
            pend_data_q <= pend_data_d;
            pend_reg_q <= pend_reg_d;
            rd_q <= rd_d;
            refused_q <= refused_d;
            dbb_q <= dbb_d;
            deb_q <= deb_d;
            drv_q <= drv_d;
            pause_q <= pause_d;
            restart_q <= restart_d;
            quad_q <= quad_d;
            scheme_q <= scheme_d;
            standby_q <= standby_d;
        end
    end

    assign status_one = st1_q;
    assign status_two = st2_q;
    assign status_three = st3_q;
    assign read_data = rd_q;
    assign cmd_refused = refused_q;
    assign dummy_bb = dbb_q;
    assign dummy_eb = deb_q;
    assign drive_strength = drv_q;
    assign pause_active = pause_q;
    assign restart_active = restart_q;
    assign quad_pins_data = quad_q;
    assign scheme_block_locks = scheme_q;
    assign low_standby = standby_q;
endmodule : flash_status_regs

// ===== bench/spi_host_model.sv
/*
 * Serial host side: issues one decoded command a call, two a write_guarded call.
 * Assumes the bank samples commands on the rising clock edge.
 */
`timescale 1ns/1ps
module spi_host_model (
    input wire logic clk,
    input wire logic [7:0] read_data,
    output logic cmd_valid,
    output logic [7:0] cmd_opcode,
    output logic [7:0] cmd_data
);
    initial begin
        cmd_valid = 1'b0;
        cmd_opcode = 8'h00;
        cmd_data = 8'h00;
    end
    // Released lines show the inverse, never the stale byte
    task automatic send(input logic [7:0] op, input logic [7:0] data);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_opcode = op;
        cmd_data = data;
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_opcode = ~op;
        cmd_data = ~data;
    endtask : send
    task automatic write_guarded(input logic [7:0] op, input logic [7:0] d);
        send(8'h06, 8'h00);
        send(op, d);
    endtask : write_guarded
    task automatic read_status(input logic [7:0] op, output logic [7:0] v);
        send(op, 8'h00);
        v = (op == 8'h15) ? (read_data & 8'hF5) : read_data;
    endtask : read_status
endmodule : spi_host_model

// ===== bench/flash_status_monitor.sv
/*
 * Port checker of the flash status register bank.
 * Assumes a bind onto flash_status_regs, one clock domain.
 */
`timescale 1ns/1ps
module flash_status_monitor (
    input wire logic clk,
    input wire logic nrst,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_opcode,
    input wire logic write_guard_n,
    input wire logic [7:0] status_one,
    input wire logic [7:0] status_two,
    input wire logic [7:0] status_three,
    input wire logic cmd_refused,
    input wire logic [3:0] dummy_bb,
    input wire logic [3:0] dummy_eb,
    input wire logic pause_active,
    input wire logic restart_active,
    input wire logic quad_pins_data,
    input wire logic low_standby
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    logic wr_op;
    assign wr_op = cmd_valid && cmd_opcode inside {8'h01, 8'h31, 8'h11};
    chk_permit_set: assert property (
        cmd_valid && cmd_opcode == 8'h06 && !status_one[0] |=> status_one[1])
        else $error("write enable left permit clear");
    chk_busy_ignore: assert property (
        cmd_valid && status_one[0] && cmd_opcode inside {8'h06, 8'h04,
        8'h01, 8'h31, 8'h11, 8'h02, 8'h20, 8'hD8, 8'hC7} |=> cmd_refused)
        else $error("command taken while busy");
    chk_needs_permit: assert property (
        cmd_valid && cmd_opcode inside {8'h02, 8'h20, 8'hD8, 8'hC7} &&
        status_one[1:0] == 2'b00 |=> cmd_refused && !status_one[0])
        else $error("program or erase started without permit");
    chk_guard_block: assert property (
        wr_op && status_one[7] && !status_two[0] && !write_guard_n
        |=> cmd_refused) else $error("status write passed low guard");
    chk_lockdown_refuse: assert property (
        wr_op && !status_one[7] && status_two[0] |=> cmd_refused)
        else $error("status write passed lockdown");
    chk_otp_refuse: assert property (
        wr_op && status_one[7] && status_two[0] |=> cmd_refused)
        else $error("status write passed permanent lock");
    chk_resume_flags: assert property (
        cmd_valid && cmd_opcode == 8'h7A |=> !status_two[7] && !status_two[2])
        else $error("resume left a paused flag set");
    chk_dummy_map: assert property (
        dummy_bb == ($past(status_three[0]) ? 4'h8 : 4'h4) &&
        dummy_eb == ($past(status_three[0]) ? 4'hA : 4'h6))
        else $error("dummy counts disagree with select bit");
    chk_standby_map: assert property (
        low_standby == !$past(status_three[4]))
        else $error("standby mode disagrees with select bit");
    chk_quad_pins: assert property (
        $past(status_two[1]) |-> quad_pins_data && !pause_active &&
        !restart_active) else $error("pin role active in quad mode");
    cover property (cmd_valid && cmd_opcode == 8'h75 && status_one[0]);
    cover property (cmd_refused && !write_guard_n);
    cover property ($fell(status_one[0]));
endmodule : flash_status_monitor
bind flash_status_regs flash_status_monitor flash_status_monitor_inst (
    .clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
    .write_guard_n(write_guard_n), .status_one(status_one),
    .status_two(status_two), .status_three(status_three),
    .cmd_refused(cmd_refused), .dummy_bb(dummy_bb), .dummy_eb(dummy_eb),
    .pause_active(pause_active), .restart_active(restart_active),
    .quad_pins_data(quad_pins_data), .low_standby(low_standby));

// ===== bench/tb.sv
/*
 * Self-checking bench of the flash status register bank.
 * Assumes the host model issues every command.
 */
`timescale 1ns/1ps
module tb;
    localparam logic [15:0] WR_CYC = 16'h0004;
    logic clk;
    logic nrst;
    logic write_guard_n;
    logic shared_pin_n;
    logic cmd_valid;
    logic [7:0] cmd_opcode, cmd_data;
    logic [7:0] status_one, status_two, status_three, read_data;
    logic [3:0] dummy_bb, dummy_eb;
    logic [1:0] drive_strength;
    logic cmd_refused, pause_active, restart_active, quad_pins_data;
    logic scheme_block_locks, low_standby;
    int miscompares;
    int check_count;
    always #12.5 clk = ~clk;
    flash_status_regs #(.WRITE_CYCLES(WR_CYC), .PROGRAM_CYCLES(WR_CYC),
        .ERASE_CYCLES(16'h0008)) flash_status_regs_inst (
        .clk(clk), .nrst(nrst), .cmd_valid(cmd_valid),
        .cmd_opcode(cmd_opcode), .cmd_data(cmd_data),
        .write_guard_n(write_guard_n), .shared_pin_n(shared_pin_n),
        .status_one(status_one), .status_two(status_two),
        .status_three(status_three), .read_data(read_data),
        .cmd_refused(cmd_refused), .dummy_bb(dummy_bb),
        .dummy_eb(dummy_eb), .drive_strength(drive_strength),
        .pause_active(pause_active), .restart_active(restart_active),
        .quad_pins_data(quad_pins_data),
        .scheme_block_locks(scheme_block_locks), .low_standby(low_standby));
    spi_host_model spi_host_model_inst (.clk(clk), .read_data(read_data),
        .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_data(cmd_data));
    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        if (miscompares == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    task automatic cmd(input logic [7:0] op, input logic [7:0] d);
        spi_host_model_inst.send(op, d);
    endtask : cmd
    task automatic guarded(input logic [7:0] op, input logic [7:0] d);
        spi_host_model_inst.write_guarded(op, d);
    endtask : guarded
    task automatic wait_idle(output int n);
        n = 0;
        while (status_one[0] === 1'b1 && n < 400) begin
            n++;
            @(negedge clk);
        end
    endtask : wait_idle
    task automatic wr(input logic [7:0] op, input logic [7:0] d);
        int n;
        guarded(op, d);
        wait_idle(n);
        repeat (2) @(negedge clk);
    endtask : wr
    task automatic t_reset();
        check("st1", status_one, 8'h00);
        check("st2", status_two, 8'h00);
        check("st3", status_three, 8'h10);
        check("dummy_bb", dummy_bb, 8'h04);
        check("dummy_eb", dummy_eb, 8'h06);
    endtask : t_reset
    task automatic t_config();
        int n;
        logic [7:0] v;
        shared_pin_n = 1'b0;
        cmd(8'h06, 8'h00);
        check("permit", status_one[1], 8'h01);
        cmd(8'h11, 8'hFF);
        check("busy", status_one[1:0], 8'h01);
        wait_idle(n);
        check("busy_len", n[7:0], WR_CYC[7:0] + 8'h02);
        repeat (2) @(negedge clk);
        spi_host_model_inst.read_status(8'h15, v);
        check("st3_read", v, 8'hF5);
        check("dummy_bb", dummy_bb, 8'h08);
        check("dummy_eb", dummy_eb, 8'h0A);
        check("drive", drive_strength, 8'h03);
        check("standby", low_standby, 8'h00);
        check("scheme", scheme_block_locks, 8'h01);
        check("pins", {pause_active, restart_active}, 8'h01);
        wr(8'h11, 8'h00);
        check("standby", low_standby, 8'h01);
        check("scheme", scheme_block_locks, 8'h00);
        check("pins", {pause_active, restart_active}, 8'h02);
        wr(8'h31, 8'h02);
        check("quad", quad_pins_data, 8'h01);
        check("pins", {pause_active, restart_active}, 8'h00);
        wr(8'h31, 8'h00);
        shared_pin_n = 1'b1;
    endtask : t_config
    task automatic t_busy();
        int n;
        guarded(8'h01, 8'h7C);
        cmd(8'h06, 8'h00);
        check("refused", cmd_refused, 8'h01);
        cmd(8'h05, 8'h00);
        check("read_ok", cmd_refused, 8'h00);
        wait_idle(n);
        cmd(8'h05, 8'h00);
        check("st1_read", read_data, 8'h7C);
        wr(8'h31, 8'h40);
        check("st2", status_two, 8'h40);
        cmd(8'h35, 8'h00);
        check("st2_read", read_data, 8'h40);
        wr(8'h01, 8'h00);
        wr(8'h31, 8'h00);
        cmd(8'h06, 8'h00);
        cmd(8'h04, 8'h00);
        check("disable", status_one[1], 8'h00);
    endtask : t_busy
    task automatic t_suspend();
        int n;
        logic [7:0] ops [4] = '{8'h02, 8'h20, 8'hD8, 8'hC7};
        logic [7:0] flags [4] = '{8'h04, 8'h80, 8'h80, 8'h80};
        for (int i = 0; i < 4; i++) begin
            cmd(ops[i], 8'h00);
            check("no_permit", {cmd_refused, status_one[0]}, 8'h02);
            guarded(ops[i], 8'h00);
            cmd(8'h75, 8'h00);
            check("paused", status_one[0], 8'h00);
            check("flags", status_two & 8'h84, flags[i]);
            cmd(8'h7A, 8'h00);
            check("flags", status_two & 8'h84, 8'h00);
            check("busy", status_one[0], 8'h01);
            wait_idle(n);
            check("permit", status_one[1:0], 8'h00);
        end
    endtask : t_suspend
    task automatic t_power_cycle();
        guarded(8'h20, 8'h00);
        cmd(8'h75, 8'h00);
        cmd(8'h06, 8'h00);
        check("pre_cycle", status_one[1], 8'h01);
        nrst = 1'b0;
        @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        check("cycle_flags", status_two, 8'h00);
        check("cycle_permit", status_one, 8'h00);
    endtask : t_power_cycle
    task automatic t_lock();
        write_guard_n = 1'b0;
        wr(8'h01, 8'h80);
        check("mode_01", status_one, 8'h80);
        guarded(8'h11, 8'h01);
        check("guard_low", cmd_refused, 8'h01);
        write_guard_n = 1'b1;
        wr(8'h11, 8'h01);
        check("guard_high", status_three, 8'h01);
        wr(8'h01, 8'h00);
        wr(8'h31, 8'h01);
        check("mode_10", status_two, 8'h01);
        guarded(8'h11, 8'h00);
        check("lockdown", cmd_refused, 8'h01);
        cmd(8'h99, 8'h00);
        check("unlocked", status_two[0], 8'h00);
        wr(8'h01, 8'h80);
        wr(8'h31, 8'h01);
        guarded(8'h01, 8'h00);
        check("permanent", cmd_refused, 8'h01);
        cmd(8'h99, 8'h00);
        check("locks", {status_two[0], status_one[7]}, 8'h03);
    endtask : t_lock
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        write_guard_n = 1'b1;
        shared_pin_n = 1'b1;
        miscompares = 0;
        check_count = 0;
        repeat (16) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        t_reset();
        t_config();
        t_busy();
        t_suspend();
        t_power_cycle();
        t_lock();
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end
endmodule : tb
